/* File: pkg/cc_consts.svh */
// Offsets, field codes, reset values and limits of the converter register block.
`ifndef CC_CONSTS_SVH
`define CC_CONSTS_SVH
`define CC_ADDR_W 12
`define CC_OFF_CONFIG 12'h080
`define CC_OFF_MIX_POS 12'h084
`define CC_OFF_STEP 12'h088
`define CC_OFF_IRQ_EN 12'h0A0
`define CC_OFF_IRQ_MASKED 12'h0A4
`define CC_OFF_IRQ_RAW 12'h0A8
`define CC_OFF_IRQ_CLR 12'h0AC
`define CC_OFF_TUNE_A 12'h100
`define CC_OFF_TUNE_B 12'h500
`define CC_TUNE_SPAN 12'h080
`define CC_MAX_CARRIERS 30
`define CC_IRQ_W 3
`define CC_IRQ_EN_RESET 3'h7
`define CC_STD_LTE 4'h0
`define CC_STD_TDSCDMA 4'h1
`define CC_STD_WCDMA 4'h2
`define CC_BW_LTE_1M4 6'h01
`define CC_BW_LTE_3M 6'h03
`define CC_BW_LTE_5M 6'h05
`define CC_BW_LTE_10M 6'h0A
`define CC_BW_LTE_15M 6'h0F
`define CC_BW_LTE_20M 6'h14
`define CC_BW_TDS 6'h02
`define CC_BW_TDS_2X 6'h06
`define CC_BW_WCDMA 6'h04
`define CC_BW_WCDMA_2X 6'h08
`endif

/* File: pkg/cc_pkg.sv */
// Shared types of the converter register block.
`default_nettype none
`include "cc_consts.svh"
package cc_pkg;
  typedef logic [31:0] word_t;
  typedef logic [`CC_ADDR_W-1:0] addr_t;
  typedef logic [`CC_IRQ_W-1:0] irq_vec_t;
  typedef logic [4:0] carrier_idx_t;
endpackage : cc_pkg
`default_nettype wire

/* File: design/converter_config_irq_regs.sv */
// Configuration, interrupt and banked carrier tuning registers of the converter.
//
// Operation
// - Standard 0000 reports bandwidth codes 01,03,05,0A,0F,14; other pairings reserved.
// - Standard 0001 uses 02/06, 0010 uses 04/08; second codes downconverter only.
// - Carrier count sits in the low bits of the configuration word.
// - Configuration, mixing positions and carrier step are build-time constants.
// - Offset 0x084 reads the mixing positions count.
// - Tuning values lie in -mrm/2 .. mrm/2-1; phases in 0 .. mrm-1.
// - Offset 0x088 reads the carrier step in hertz.
// - Interrupt registers: bit 2 lost, bit 1 length, bit 0 missing.
// - Enable register at 0x0A0 gates each raw status onto its output.
// - Register-port reset sets every interrupt enable bit.
// - Offset 0x0A4 reads raw AND enable, equal to interrupt outputs.
// - Masked status clears on datapath reset; register-port reset makes it equal raw.
// - Offset 0x0A8 reads raw status; datapath reset clears it only.
// - Writing ones to 0x0AC clears those raw bits; zeros do nothing.
// - Tuning banks: carrier n at 0x100+4(n-1) and 0x500+4(n-1).
// - Each tuning register holds frequency as multiple of carrier step.
// - Writes to the active bank get a slave error.
// - Out-of-range tuning writes get a slave error and change nothing.
// - Accesses to carriers beyond the count get a slave error.
// - Shadow bank values reach the datapath only after a bank swap.
`timescale 1ns/10ps
`default_nettype none
`include "cc_consts.svh"

module converter_config_irq_regs
#(
  parameter int NUM_CARRIERS = 4,
  parameter logic [3:0] STANDARD = `CC_STD_LTE,
  parameter logic [5:0] BW_CODE = `CC_BW_LTE_5M,
  parameter bit IS_DOWNCONVERTER = 1'b0,
  parameter logic [1:0] DIGITAL_IF = 2'b00,
  parameter bit PROG_FREQ = 1'b1,
  parameter bit PROG_GAIN = 1'b0,
  parameter logic [31:0] MIX_POSITIONS = 32'h0000_1000,
  parameter logic [31:0] STEP_HZ = 32'h0000_3A98
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic dp_rst_in,
  input wire cc_pkg::irq_vec_t evt_in,
  input wire logic bank_sel_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire cc_pkg::addr_t paddr_in,
  input wire cc_pkg::word_t pwdata_in,
  output cc_pkg::word_t prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output cc_pkg::irq_vec_t irq_out,
  output logic [NUM_CARRIERS*32-1:0] tune_active_out
);
  import cc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Build-time checks and constant words.

  localparam bit LTE_OK = (STANDARD == `CC_STD_LTE) &&
    (BW_CODE inside {`CC_BW_LTE_1M4, `CC_BW_LTE_3M, `CC_BW_LTE_5M,
                     `CC_BW_LTE_10M, `CC_BW_LTE_15M, `CC_BW_LTE_20M});
  localparam bit TDS_OK = (STANDARD == `CC_STD_TDSCDMA) &&
    ((BW_CODE == `CC_BW_TDS) || ((BW_CODE == `CC_BW_TDS_2X) && IS_DOWNCONVERTER));
  localparam bit WCDMA_OK = (STANDARD == `CC_STD_WCDMA) &&
    ((BW_CODE == `CC_BW_WCDMA) || ((BW_CODE == `CC_BW_WCDMA_2X) && IS_DOWNCONVERTER));

  if (!(LTE_OK || TDS_OK || WCDMA_OK))
  begin : g_bad_bandwidth
    $error("Reserved standard and bandwidth pairing.");
  end
  if (NUM_CARRIERS < 1 || NUM_CARRIERS > `CC_MAX_CARRIERS)
  begin : g_bad_count
    $error("Carrier count outside the supported range.");
  end

  // The words below never change while running.
  localparam word_t CONFIG_WORD = {4'h0, DIGITAL_IF, BW_CODE, STANDARD,
    IS_DOWNCONVERTER, PROG_GAIN, 1'b0, PROG_FREQ, 6'h00, 6'(NUM_CARRIERS)};
  localparam carrier_idx_t NC_IDX = 5'(NUM_CARRIERS);
  localparam bit TUNE_WRITABLE = PROG_FREQ && (NUM_CARRIERS > 1);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    irq_vec_t en;
    logic rdy;
    logic err;
    word_t rdata;
    logic [NUM_CARRIERS-1:0][31:0] tune_a;
    logic [NUM_CARRIERS-1:0][31:0] tune_b;
    logic [NUM_CARRIERS-1:0][31:0] active;
  } regs_t;

  // Interrupt status answers to the datapath reset only, so it lives apart.
  typedef struct packed {
    irq_vec_t raw;
    irq_vec_t masked;
  } irq_state_t;

  regs_t cur_ff;
  regs_t nxt_cur;
  irq_state_t irq_ff;
  irq_state_t nxt_irq;
  irq_vec_t clr;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic in_window(input addr_t a, input addr_t base);
    return (a >= base) && (a < addr_t'(base + `CC_TUNE_SPAN));
  endfunction : in_window

  // Signed tuning value against the half-range of the mixing positions.
  function automatic logic tune_legal(input word_t v);
    logic signed [33:0] sv;
    logic signed [33:0] half;
    sv = 34'(signed'(v));
    half = signed'(34'(MIX_POSITIONS >> 1));
    return (sv >= -half) && (sv < half);
  endfunction : tune_legal

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic take;
  logic is_a;
  logic is_b;
  logic is_tune;
  carrier_idx_t idx;
  logic idx_ok;
  logic hits_active;
  logic val_ok;
  irq_vec_t wdata_irq;

  assign take = psel_in && penable_in && !cur_ff.rdy;
  assign is_a = in_window(paddr_in, `CC_OFF_TUNE_A);
  assign is_b = in_window(paddr_in, `CC_OFF_TUNE_B);
  assign is_tune = is_a || is_b;
  assign idx = paddr_in[6:2];
  assign idx_ok = idx < NC_IDX;
  assign hits_active = is_a ? !bank_sel_in : bank_sel_in;
  assign val_ok = tune_legal(pwdata_in);
  assign wdata_irq = pwdata_in[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Register access and datapath view.

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.rdy = 1'b0;
    nxt_cur.err = 1'b0;
    clr = '0;
    for (int i = 0; i < NUM_CARRIERS; i++)
    begin
      nxt_cur.active[i] = bank_sel_in ? cur_ff.tune_b[i] : cur_ff.tune_a[i];
    end
    if (take)
    begin
      nxt_cur.rdy = 1'b1;
      nxt_cur.rdata = '0;
      if (is_tune)
      begin
        if (!idx_ok)
        begin
          nxt_cur.err = 1'b1;
        end
        else if (!pwrite_in)
        begin
          nxt_cur.rdata = is_a ? cur_ff.tune_a[idx] : cur_ff.tune_b[idx];
        end
        else if (hits_active || !TUNE_WRITABLE)
        begin
          nxt_cur.err = 1'b1;
        end
        else if (!val_ok)
        begin
          nxt_cur.err = 1'b1;
        end
        else if (is_a)
        begin
          nxt_cur.tune_a[idx] = pwdata_in;
        end
        else
        begin
          nxt_cur.tune_b[idx] = pwdata_in;
        end
      end
      else
      begin
        case (paddr_in)
          `CC_OFF_CONFIG:
          begin
            nxt_cur.err = pwrite_in;
            nxt_cur.rdata = CONFIG_WORD;
          end
          `CC_OFF_MIX_POS:
          begin
            nxt_cur.err = pwrite_in;
            nxt_cur.rdata = MIX_POSITIONS;
          end
          `CC_OFF_STEP:
          begin
            nxt_cur.err = pwrite_in;
            nxt_cur.rdata = STEP_HZ;
          end
          `CC_OFF_IRQ_EN:
          begin
            if (pwrite_in)
            begin
              nxt_cur.en = wdata_irq;
            end
            nxt_cur.rdata = {29'h0, cur_ff.en};
          end
          `CC_OFF_IRQ_MASKED:
          begin
            nxt_cur.err = pwrite_in;
            nxt_cur.rdata = {29'h0, irq_ff.masked};
          end
          `CC_OFF_IRQ_RAW:
          begin
            nxt_cur.err = pwrite_in;
            nxt_cur.rdata = {29'h0, irq_ff.raw};
          end
          `CC_OFF_IRQ_CLR:
          begin
            if (pwrite_in)
            begin
              clr = wdata_irq;
            end
          end
          default:
          begin
            nxt_cur.err = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cur_ff <= '0;
      cur_ff.en <= `CC_IRQ_EN_RESET;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status.

  // An event in the same cycle as a clear keeps its bit set.
  always_comb
  begin
    nxt_irq = irq_ff;
    if (dp_rst_in)
    begin
      nxt_irq.raw = '0;
    end
    else
    begin
      nxt_irq.raw = (irq_ff.raw & ~clr) | evt_in;
    end
    nxt_irq.masked = nxt_irq.raw & nxt_cur.en;
  end

  // No register-port reset here; the datapath reset clears the status.
  always_ff @(posedge clk_sys_in)
  begin
    irq_ff <= nxt_irq;
  end

  assign prdata_out = cur_ff.rdata;
  assign pready_out = cur_ff.rdy;
  assign pslverr_out = cur_ff.err;
  assign irq_out = irq_ff.masked;
  assign tune_active_out = cur_ff.active;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  sequence s_take;
    psel_in && penable_in && !pready_out;
  endsequence

  sequence s_answer;
    pready_out ##1 !pready_out;
  endsequence

  property p_handshake;
    s_take |=> s_answer;
  endproperty
  a_handshake: assert property (p_handshake) else $error("Bus answer not one cycle.");

  property p_masked;
    irq_out == (irq_ff.raw & cur_ff.en);
  endproperty
  a_masked: assert property (p_masked) else $error("Interrupt outputs differ from raw and enable.");

  property p_raw_set;
    !dp_rst_in |=> ((irq_ff.raw & $past(evt_in)) == $past(evt_in));
  endproperty
  a_raw_set: assert property (p_raw_set) else $error("Event did not set its raw bit.");

  property p_dp_clear;
    dp_rst_in |=> (irq_ff.raw == '0) && (irq_out == '0);
  endproperty
  a_dp_clear: assert property (p_dp_clear) else $error("Datapath reset left status set.");

  property p_clear;
    (s_take and (pwrite_in && paddr_in == `CC_OFF_IRQ_CLR && evt_in == '0 && !dp_rst_in))
      |=> ((irq_ff.raw & $past(wdata_irq)) == '0) && !pslverr_out;
  endproperty
  a_clear: assert property (p_clear) else $error("Clear write left a raw bit set.");

  property p_enable;
    (s_take and (pwrite_in && paddr_in == `CC_OFF_IRQ_EN)) |=> cur_ff.en == $past(wdata_irq);
  endproperty
  a_enable: assert property (p_enable) else $error("Enable write not stored.");

  property p_active_err;
    (s_take and (pwrite_in && is_tune && idx_ok && hits_active))
      |=> pslverr_out && $stable(cur_ff.tune_a) && $stable(cur_ff.tune_b);
  endproperty
  a_active_err: assert property (p_active_err) else $error("Active bank write accepted.");

  property p_range_err;
    (s_take and (pwrite_in && is_tune && idx_ok && !val_ok))
      |=> pslverr_out && $stable(cur_ff.tune_a) && $stable(cur_ff.tune_b);
  endproperty
  a_range_err: assert property (p_range_err) else $error("Out-of-range tuning accepted.");

  property p_index_err;
    (s_take and (is_tune && !idx_ok)) |=> pslverr_out;
  endproperty
  a_index_err: assert property (p_index_err) else $error("Missing carrier not refused.");

  property p_mix_read;
    (s_take and (!pwrite_in && paddr_in == `CC_OFF_MIX_POS))
      |=> prdata_out == MIX_POSITIONS && !pslverr_out;
  endproperty
  a_mix_read: assert property (p_mix_read) else $error("Mixing positions read wrong.");

  property p_shadow;
    $stable(bank_sel_in) [*2] |-> $stable(tune_active_out);
  endproperty
  a_shadow: assert property (p_shadow) else $error("Shadow write reached the datapath.");

endmodule : converter_config_irq_regs
`default_nettype wire

/* File: test/cc_host_model.sv */
// Host model that drives the register bus of the converter block.
`timescale 1ns/10ps
`default_nettype none
module cc_host_model
(
  input wire logic clk_sys_in,
  input wire cc_pkg::word_t prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output var logic psel_out,
  output var logic penable_out,
  output var logic pwrite_out,
  output var cc_pkg::addr_t paddr_out,
  output var cc_pkg::word_t pwdata_out
);
  import cc_pkg::*;
  initial
  begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'hFFF;
    pwdata_out = 32'hA5A5_A5A5;
  end
  ////////////////////////////////////////////////////////////////////////
  // One access: request held through the edge that samples the ready pulse.
  task automatic access(input logic wr, input addr_t a, input word_t d, output word_t rd, output logic err);
    int n;
    rd = 'x;
    err = 1'bx;
    @(negedge clk_sys_in);
    psel_out = 1'b1;
    penable_out = 1'b0;
    pwrite_out = wr;
    paddr_out = a;
    pwdata_out = d;
    @(negedge clk_sys_in);
    penable_out = 1'b1;
    for (n = 0; n < 8; n++)
    begin
      @(negedge clk_sys_in);
      if (pready_in === 1'b1)
      begin
        rd = prdata_in;
        err = pslverr_in;
        break;
      end
    end
    @(negedge clk_sys_in);
    psel_out = 1'b0;
    penable_out = 1'b0;
    // Released lines carry the inverse so stale values are never mistaken for live ones.
    paddr_out = ~a;
    pwdata_out = ~d;
  endtask : access
endmodule : cc_host_model
`default_nettype wire

/* File: test/converter_config_irq_regs_tb.sv */
// Self-checking testbench of the converter register block.
`timescale 1ns/10ps
`default_nettype none
`include "cc_consts.svh"
module converter_config_irq_regs_tb;
  import cc_pkg::*;
  localparam logic [31:0] MIX = 32'h0000_1000;
  localparam logic [31:0] STEP = 32'h0000_3A98;
  logic clk_sys_in, rst_in, dp_rst_in, bank_sel_in, psel, penable, pwrite, pready, pslverr, err;
  irq_vec_t evt_in, irq;
  addr_t paddr;
  word_t pwdata, prdata, rd;
  logic [127:0] tune;
  int n_errors = 0;
  int tests_run = 0;
  converter_config_irq_regs #(.NUM_CARRIERS(4), .MIX_POSITIONS(MIX), .STEP_HZ(STEP)) DUT
  (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .dp_rst_in(dp_rst_in), .evt_in(evt_in),
    .bank_sel_in(bank_sel_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .irq_out(irq), .tune_active_out(tune)
  );
  cc_host_model host
  (
    .clk_sys_in(clk_sys_in), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata)
  );
  initial
  begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input word_t exp, input word_t got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input addr_t a, input word_t exp, input logic eerr);
    host.access(1'b0, a, 32'h0, rd, err);
    if (!eerr)
      chk("read data", exp, rd);
    chk("read error", {31'h0, eerr}, {31'h0, err});
  endtask : rd_chk
  task automatic wr_chk(input addr_t a, input word_t d, input logic eerr);
    host.access(1'b1, a, d, rd, err);
    chk("write error", {31'h0, eerr}, {31'h0, err});
  endtask : wr_chk
  task automatic pulse(input irq_vec_t e);
    @(negedge clk_sys_in);
    evt_in = e;
    @(negedge clk_sys_in);
    evt_in = 3'h0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge clk_sys_in);
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    rst_in = 1'b1;
    dp_rst_in = 1'b1;
    bank_sel_in = 1'b0;
    evt_in = 3'h0;
    repeat (3) @(negedge clk_sys_in);
    rst_in = 1'b0;
    dp_rst_in = 1'b0;
    rd_chk(`CC_OFF_CONFIG, 32'h0050_1004, 1'b0);
    rd_chk(`CC_OFF_MIX_POS, MIX, 1'b0);
    rd_chk(`CC_OFF_STEP, STEP, 1'b0);
    rd_chk(`CC_OFF_IRQ_EN, 32'h7, 1'b0);
    rd_chk(`CC_OFF_IRQ_RAW, 32'h0, 1'b0);
    wr_chk(`CC_OFF_STEP, 32'h1, 1'b1);
    rd_chk(`CC_OFF_STEP, STEP, 1'b0);
    rd_chk(12'h010, 32'h0, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      pulse(irq_vec_t'(1 << i));
      chk("irq", 32'h1 << i, {29'h0, irq});
      rd_chk(`CC_OFF_IRQ_MASKED, 32'h1 << i, 1'b0);
      wr_chk(`CC_OFF_IRQ_CLR, 32'h0, 1'b0);
      rd_chk(`CC_OFF_IRQ_RAW, 32'h1 << i, 1'b0);
      wr_chk(`CC_OFF_IRQ_CLR, 32'h1 << i, 1'b0);
      chk("irq", 32'h0, {29'h0, irq});
    end
    wr_chk(`CC_OFF_IRQ_EN, 32'h0, 1'b0);
    pulse(3'h7);
    chk("irq", 32'h0, {29'h0, irq});
    rd_chk(`CC_OFF_IRQ_MASKED, 32'h0, 1'b0);
    rd_chk(`CC_OFF_IRQ_RAW, 32'h7, 1'b0);
    wr_chk(`CC_OFF_IRQ_EN, 32'h5, 1'b0);
    chk("irq", 32'h5, {29'h0, irq});
    rd_chk(`CC_OFF_IRQ_MASKED, 32'h5, 1'b0);
    @(negedge clk_sys_in);
    rst_in = 1'b1;
    @(negedge clk_sys_in);
    rst_in = 1'b0;
    @(negedge clk_sys_in);
    chk("irq", 32'h7, {29'h0, irq});
    rd_chk(`CC_OFF_IRQ_EN, 32'h7, 1'b0);
    rd_chk(`CC_OFF_IRQ_RAW, 32'h7, 1'b0);
    @(negedge clk_sys_in);
    dp_rst_in = 1'b1;
    @(negedge clk_sys_in);
    dp_rst_in = 1'b0;
    chk("irq", 32'h0, {29'h0, irq});
    rd_chk(`CC_OFF_IRQ_RAW, 32'h0, 1'b0);
    // The event lands on the very edge that takes the clear write, so the bit must stay set.
    fork
      wr_chk(`CC_OFF_IRQ_CLR, 32'h1, 1'b0);
      begin
        repeat (2) @(negedge clk_sys_in);
        evt_in = 3'h1;
        @(negedge clk_sys_in);
        evt_in = 3'h0;
      end
    join
    rd_chk(`CC_OFF_IRQ_RAW, 32'h1, 1'b0);
    wr_chk(`CC_OFF_TUNE_A, 32'h1, 1'b1);
    wr_chk(`CC_OFF_TUNE_B, 32'h0000_07FF, 1'b0);
    wr_chk(`CC_OFF_TUNE_B + 12'h004, 32'h0000_0800, 1'b1);
    rd_chk(`CC_OFF_TUNE_B + 12'h004, 32'h0, 1'b0);
    wr_chk(`CC_OFF_TUNE_B + 12'h004, 32'hFFFF_F800, 1'b0);
    wr_chk(`CC_OFF_TUNE_B + 12'h008, 32'hFFFF_F7FF, 1'b1);
    rd_chk(`CC_OFF_TUNE_B + 12'h008, 32'h0, 1'b0);
    rd_chk(`CC_OFF_TUNE_B, 32'h0000_07FF, 1'b0);
    rd_chk(`CC_OFF_TUNE_B + 12'h010, 32'h0, 1'b1);
    wr_chk(`CC_OFF_TUNE_B + 12'h010, 32'h0, 1'b1);
    chk("tune", 32'h0, tune[31:0]);
    @(negedge clk_sys_in);
    bank_sel_in = 1'b1;
    @(negedge clk_sys_in);
    chk("tune", 32'h0000_07FF, tune[31:0]);
    chk("tune", 32'hFFFF_F800, tune[63:32]);
    wr_chk(`CC_OFF_TUNE_B, 32'h0, 1'b1);
    wr_chk(`CC_OFF_TUNE_A + 12'h00C, 32'h5, 1'b0);
    rd_chk(`CC_OFF_TUNE_A + 12'h00C, 32'h5, 1'b0);
    report_and_stop();
  end
endmodule : converter_config_irq_regs_tb
`default_nettype wire
